// ===== rtl/uart_line_defs.vh
// register offsets, field positions, reset values and sizes for the uart line block
`ifndef UART_LINE_DEFS_VH
`define UART_LINE_DEFS_VH
`define OFS_DATA        12'h000
`define OFS_IRQ_EN      12'h004
`define OFS_FIFO_CTRL   12'h008
`define OFS_LINE_CTRL   12'h00C
`define OFS_STATUS      12'h01C
`define FC_QUEUE_EN     0
`define FC_RX_FLUSH     1
`define FC_TX_FLUSH     2
`define FC_DMA_SEL      3
`define LC_DIV_ACCESS   7
`define LC_BREAK        6
`define LC_FIXED_PAR    5
`define LC_EVEN_PAR     4
`define LC_PAR_EN       3
`define LC_STOP_CNT     2
`define LC_RESET        8'h00
`define DIV_RESET       16'h0001
`define QUEUE_DEPTH     16
`define PTR_W           5
`define TX_IDLE         2'h0
`define TX_SHIFT        2'h1
`define TX_STOP         2'h2
`define RX_IDLE         2'h0
`define RX_START        2'h1
`define RX_DATA         2'h2
`define RX_STOP         2'h3
`endif

// ===== rtl/uart_line_ctrl.v
// uart queue control, line format control, transmitter and receiver with apb registers
`timescale 1ns/100ps
`include "uart_line_defs.vh"
module uart_line_ctrl (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // serial line
  input  wire        serial_in,
  output reg         serial_out,
  // queue flush pulses
  output reg         tx_flush_pulse,
  output reg         rx_flush_pulse
);

  // parity value for the character; fixed parity overrides the computed one
  function par_fn;
    input [7:0] d;
    input [7:0] fmt;
    reg   [7:0] m;
    begin
      m = 8'hFF >> (2'd3 - fmt[1:0]);
      if (fmt[`LC_FIXED_PAR])
        par_fn = ~fmt[`LC_EVEN_PAR];
      else
        par_fn = (^(d & m)) ^ ~fmt[`LC_EVEN_PAR];
    end
  endfunction

  reg  [7:0]  lcr_q;
  reg  [7:0]  irq_en_q;
  reg  [15:0] div_q;
  reg  [7:0]  txq_mem [0:`QUEUE_DEPTH-1];
  reg  [9:0]  rxq_mem [0:`QUEUE_DEPTH-1];
  reg  [4:0]  tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
  reg  [1:0]  tx_st_q, rx_st_q;
  reg  [17:0] tx_tmr_q, rx_tmr_q;
  reg  [9:0]  tx_sh_q;
  reg  [3:0]  tx_bits_q, rx_bits_q;
  reg  [1:0]  tx_stop_q;
  reg  [8:0]  rx_sh_q;
  reg  [7:0]  rx_fmt_q;
  reg         rx_in_q;

  wire        wr_acc   = psel & penable & pwrite;
  wire        rd_acc   = psel & penable & ~pwrite;
  wire        setup    = psel & ~penable;
  wire        div_sel  = lcr_q[`LC_DIV_ACCESS];
  wire [15:0] div_eff  = (div_q == 16'h0000) ? 16'h0001 : div_q;
  wire [17:0] bit_time = {1'b0, div_eff, 1'b0} - 18'h00001;
  wire [4:0]  tx_lvl   = tx_wp_q - tx_rp_q;
  wire [4:0]  rx_lvl   = rx_wp_q - rx_rp_q;
  wire        tx_full  = (tx_lvl == 5'h10);
  wire        rx_full  = (rx_lvl == 5'h10);
  wire        tx_empty = (tx_lvl == 5'h00);
  wire        rx_empty = (rx_lvl == 5'h00);
  wire        hit_data = (paddr == `OFS_DATA);
  wire        hit_irq  = (paddr == `OFS_IRQ_EN);
  wire        hit_fc   = (paddr == `OFS_FIFO_CTRL);
  wire        hit_lc   = (paddr == `OFS_LINE_CTRL);
  wire        hit_st   = (paddr == `OFS_STATUS);
  wire        mapped   = hit_data | hit_irq | hit_fc | hit_lc | hit_st;
  wire        tx_push  = wr_acc & hit_data & ~div_sel & ~tx_full;
  wire        rx_pop   = rd_acc & hit_data & ~div_sel & ~rx_empty;
  wire        tx_start = (tx_st_q == `TX_IDLE) & ~tx_empty;
  wire        tx_tick  = (tx_tmr_q == 18'h00000);
  wire        rx_tick  = (rx_tmr_q == 18'h00000);
  wire        rx_push  = (rx_st_q == `RX_STOP) & rx_tick & ~rx_full;

  // frame being loaded: data, optional parity above the last data bit
  wire [7:0]  tx_fmt   = lcr_q;
  wire [7:0]  tx_mask  = 8'hFF >> (2'd3 - tx_fmt[1:0]);
  wire [7:0]  tx_dat   = txq_mem[tx_rp_q[3:0]] & tx_mask;
  wire [8:0]  tx_par   = {8'h00, par_fn(tx_dat, tx_fmt)} << ({2'b00, tx_fmt[1:0]} + 4'h5);
  wire [3:0]  tx_nbits = 4'd6 + {2'b00, tx_fmt[1:0]} + {3'b000, tx_fmt[`LC_PAR_EN]};
  // unused bits above the frame are mark, else a short frame shifts a 0 stop bit
  wire [8:0]  tx_fill  = 9'h1FF << (tx_nbits - 4'h1);

  // received bits sit at the top of the shifter; align them down
  wire [3:0]  rx_n     = 4'd5 + {2'b00, rx_fmt_q[1:0]} + {3'b000, rx_fmt_q[`LC_PAR_EN]};
  wire [8:0]  rx_al    = rx_sh_q >> (4'd9 - rx_n);
  wire [7:0]  rx_dat   = rx_al[7:0] & (8'hFF >> (2'd3 - rx_fmt_q[1:0]));
  wire        rx_pbit  = rx_al[{2'b00, rx_fmt_q[1:0]} + 4'h5];
  wire        rx_perr  = rx_fmt_q[`LC_PAR_EN] & (rx_pbit != par_fn(rx_dat, rx_fmt_q));

  // apb slave: zero wait states, read data prepared in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= ~mapped;
        prdata  <= 32'h00000000;
        if (hit_data)
          prdata <= div_sel ? {24'h000000, div_q[7:0]} :
                              {24'h000000, rxq_mem[rx_rp_q[3:0]][7:0]};
        if (hit_irq)
          prdata <= div_sel ? {24'h000000, div_q[15:8]} : {24'h000000, irq_en_q};
        if (hit_fc)
          prdata <= {29'h00000000, tx_flush_pulse, rx_flush_pulse, 1'b1};
        if (hit_lc)
          prdata <= {24'h000000, lcr_q};
        if (hit_st)
          prdata <= {16'h0000, rx_lvl, tx_lvl, 3'h0, (tx_st_q != `TX_IDLE),
                     rxq_mem[rx_rp_q[3:0]][9:8] & {2{~rx_empty}}};
      end
    end
  end

  // control registers; dma select and queue enable are not stored
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lcr_q          <= `LC_RESET;
      irq_en_q       <= 8'h00;
      div_q          <= `DIV_RESET;
      tx_flush_pulse <= 1'b0;
      rx_flush_pulse <= 1'b0;
    end else begin
      tx_flush_pulse <= 1'b0;
      rx_flush_pulse <= 1'b0;
      if (wr_acc) begin
        if (hit_lc)
          lcr_q <= pwdata[7:0];
        if (hit_data & div_sel)
          div_q[7:0] <= pwdata[7:0];
        if (hit_irq & div_sel)
          div_q[15:8] <= pwdata[7:0];
        if (hit_irq & ~div_sel)
          irq_en_q <= pwdata[7:0];
        if (hit_fc & pwdata[`FC_QUEUE_EN]) begin
          tx_flush_pulse <= pwdata[`FC_TX_FLUSH];
          rx_flush_pulse <= pwdata[`FC_RX_FLUSH];
        end
      end
    end
  end

  // transmit and receive queue storage
  always @(posedge pclk) begin
    if (tx_push)
      txq_mem[tx_wp_q[3:0]] <= pwdata[7:0];
    if (rx_push)
      rxq_mem[rx_wp_q[3:0]] <= {rx_perr, ~serial_in, rx_dat};
  end

  // queue pointers; a flush pulse empties the queue on the next edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_wp_q <= 5'h00;
      tx_rp_q <= 5'h00;
      rx_wp_q <= 5'h00;
      rx_rp_q <= 5'h00;
    end else begin
      if (tx_flush_pulse) begin
        tx_wp_q <= 5'h00;
        tx_rp_q <= 5'h00;
      end else begin
        if (tx_push)
          tx_wp_q <= tx_wp_q + 5'h01;
        if (tx_start)
          tx_rp_q <= tx_rp_q + 5'h01;
      end
      if (rx_flush_pulse) begin
        rx_wp_q <= 5'h00;
        rx_rp_q <= 5'h00;
      end else begin
        if (rx_push)
          rx_wp_q <= rx_wp_q + 5'h01;
        if (rx_pop)
          rx_rp_q <= rx_rp_q + 5'h01;
      end
    end
  end

  // transmitter; bit time is twice the divisor so 1.5 stop is exact
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_st_q   <= `TX_IDLE;
      tx_tmr_q  <= 18'h00000;
      tx_sh_q   <= 10'h3FF;
      tx_bits_q <= 4'h0;
      tx_stop_q <= 2'h0;
    end else begin
      case (tx_st_q)
        `TX_IDLE: begin
          tx_sh_q <= 10'h3FF;
          if (tx_start) begin
            tx_sh_q   <= {(tx_fmt[`LC_PAR_EN] ? tx_par : 9'h000) | {1'b0, tx_dat} | tx_fill,
                          1'b0};
            tx_bits_q <= tx_nbits;
            tx_stop_q <= ~tx_fmt[`LC_STOP_CNT] ? 2'd2 :
                         ((tx_fmt[1:0] == 2'b00) ? 2'd3 : 2'd0);
            tx_tmr_q  <= bit_time;
            tx_st_q   <= `TX_SHIFT;
          end
        end
        `TX_SHIFT: begin
          tx_tmr_q <= tx_tmr_q - 18'h00001;
          if (tx_tick) begin
            tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
            tx_bits_q <= tx_bits_q - 4'h1;
            tx_tmr_q  <= bit_time;
            if (tx_bits_q == 4'h1) begin
              // stop count 0 here means four half bits
              tx_tmr_q <= {div_eff, 2'b00} - 18'h00001;
              if (tx_stop_q != 2'd0)
                tx_tmr_q <= ({2'b00, div_eff} * {16'h0000, tx_stop_q}) - 18'h00001;
              tx_st_q  <= `TX_STOP;
            end
          end
        end
        `TX_STOP: begin
          tx_tmr_q <= tx_tmr_q - 18'h00001;
          if (tx_tick)
            tx_st_q <= `TX_IDLE;
        end
        default: tx_st_q <= `TX_IDLE;
      endcase
    end
  end

  // pin driver: break overrides only the pin, the shifter runs on
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      serial_out <= 1'b1;
    else
      serial_out <= lcr_q[`LC_BREAK] ? 1'b0 : tx_sh_q[0];
  end

  // receiver; samples each bit in its middle, format latched at start
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_st_q   <= `RX_IDLE;
      rx_tmr_q  <= 18'h00000;
      rx_sh_q   <= 9'h000;
      rx_bits_q <= 4'h0;
      rx_fmt_q  <= `LC_RESET;
      rx_in_q   <= 1'b1;
    end else begin
      rx_in_q <= serial_in;
      case (rx_st_q)
        `RX_IDLE: begin
          if (rx_in_q & ~serial_in) begin
            rx_fmt_q <= lcr_q;
            rx_tmr_q <= {2'b00, div_eff} - 18'h00001;
            rx_st_q  <= `RX_START;
          end
        end
        `RX_START: begin
          rx_tmr_q <= rx_tmr_q - 18'h00001;
          if (rx_tick) begin
            rx_tmr_q  <= bit_time;
            rx_bits_q <= rx_n;
            rx_st_q   <= serial_in ? `RX_IDLE : `RX_DATA;
          end
        end
        `RX_DATA: begin
          rx_tmr_q <= rx_tmr_q - 18'h00001;
          if (rx_tick) begin
            rx_sh_q   <= {serial_in, rx_sh_q[8:1]};
            rx_bits_q <= rx_bits_q - 4'h1;
            rx_tmr_q  <= bit_time;
            if (rx_bits_q == 4'h1)
              rx_st_q <= `RX_STOP;
          end
        end
        `RX_STOP: begin
          rx_tmr_q <= rx_tmr_q - 18'h00001;
          if (rx_tick)
            rx_st_q <= `RX_IDLE;
        end
        default: rx_st_q <= `RX_IDLE;
      endcase
    end
  end

endmodule // uart_line_ctrl

// ===== verification/uart_line_checker.sv
// concurrent checks on the uart queue and line control ports
`timescale 1ns/100ps
module uart_line_checker (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // serial line and flush pulses
  input wire        serial_in,
  input wire        serial_out,
  input wire        tx_flush_pulse,
  input wire        rx_flush_pulse
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire  acc = psel && penable && pready;
  wire  fcw = acc && pwrite && paddr == 12'h008;
  logic brk_q;
  // local copy of the break bit so the pin can be judged against it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) brk_q <= 1'b0;
    else if (acc && pwrite && paddr == 12'h00C) brk_q <= pwdata[6];
  end
  tx_once_a:
    assert property (tx_flush_pulse |=> !tx_flush_pulse) else $error("tx pulse long");
  rx_once_a:
    assert property (rx_flush_pulse |=> !rx_flush_pulse) else $error("rx pulse long");
  tx_cause_a:
    assert property (fcw && pwdata[0] && pwdata[2] |=> tx_flush_pulse) else $error("no tx pulse");
  rx_cause_a:
    assert property (fcw && pwdata[0] && pwdata[1] |=> rx_flush_pulse) else $error("no rx pulse");
  flush_gate_a:
    assert property (fcw && !pwdata[0] |=> !tx_flush_pulse && !rx_flush_pulse)
      else $error("flush without enable");
  dma_none_a:
    assert property (fcw && pwdata[2:1] == 2'b00 |=> !tx_flush_pulse && !rx_flush_pulse)
      else $error("dma bit acted");
  mode_read_a:
    assert property (acc && !pwrite && paddr == 12'h008 |-> prdata[0] && !prdata[3])
      else $error("queue mode read");
  break_low_a:
    assert property (brk_q && $past(brk_q) |-> !serial_out) else $error("break not low");
  cover property (tx_flush_pulse);
  cover property (rx_flush_pulse);
  cover property (brk_q && !serial_out);
endmodule // uart_line_checker

bind uart_line_ctrl uart_line_checker chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .serial_in(serial_in), .serial_out(serial_out),
  .tx_flush_pulse(tx_flush_pulse), .rx_flush_pulse(rx_flush_pulse));

// ===== verification/serial_peer.sv
// remote serial device model driving the receive line
`timescale 1ns/100ps
module serial_peer (
  // line
  input  wire  pclk,
  output logic line
);
  initial line = 1'b1;
  // bits go out lsb first; line returns to mark level between frames
  task automatic send(input logic [11:0] bits, input int n, input int bt);
    @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      line <= bits[i];
      repeat (bt) @(posedge pclk);
    end
    line <= 1'b1;
  endtask
endmodule // serial_peer

// ===== verification/uart_fifo_and_line_control_tb_top.sv
// self-checking bench for the uart queue and line control block
`timescale 1ns/100ps
module uart_fifo_and_line_control_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, serial_in, serial_out, tx_flush_pulse, rx_flush_pulse;
  // every length, parity mode and stop count combination of interest
  logic [7:0]  lcr_tab [7] = '{8'h08, 8'h19, 8'h2A, 8'h3B, 8'h03, 8'h1F, 8'h04};
  int          n_errors, n_checks;
  uart_line_ctrl uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .serial_in(serial_in), .serial_out(serial_out),
    .tx_flush_pulse(tx_flush_pulse), .rx_flush_pulse(rx_flush_pulse));
  serial_peer peer (.pclk(pclk), .line(serial_in));
  always #50 pclk = ~pclk;
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (n_errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task t_regs;
    xfer(0, 12'h00C, 0); chk(rd, 0);
    xfer(1, 12'h008, 0); xfer(0, 12'h008, 0); chk(rd, 1);
    xfer(0, 12'h030, 0); chk(err, 1);
    xfer(1, 12'h00C, 32'h80); xfer(1, 12'h000, 32'h20); xfer(1, 12'h004, 0);
    xfer(1, 12'h00C, 32'h03); xfer(1, 12'h004, 32'h05);
    xfer(0, 12'h00C, 0); chk(rd, 32'h03);
    xfer(1, 12'h00C, 32'h83); xfer(0, 12'h000, 0); chk(rd, 32'h20);
    xfer(0, 12'h004, 0); chk(rd, 0);
    xfer(1, 12'h00C, 32'h03); xfer(0, 12'h004, 0); chk(rd, 32'h05);
  endtask
  task t_flush;
    repeat (3) xfer(1, 12'h000, 32'h5A);
    // the idle transmitter takes the first of the three at once
    xfer(0, 12'h01C, 0); chk(rd[10:6], 2);
    xfer(1, 12'h008, 32'h06); xfer(1, 12'h008, 32'h09);
    xfer(0, 12'h01C, 0); chk(rd[10:6], 2);
    xfer(1, 12'h008, 32'h0D); xfer(0, 12'h01C, 0); chk(rd[10:6], 0);
    xfer(0, 12'h008, 0); chk(rd, 1);
    peer.send({2'b11, 8'h3C, 1'b0}, 10, 64);
    repeat (64) @(posedge pclk);
    xfer(0, 12'h01C, 0); chk(rd[15:11], 1);
    xfer(1, 12'h008, 32'h03); xfer(0, 12'h01C, 0); chk(rd[15:11], 0);
    for (int k = 0; k < 300; k++) begin
      xfer(0, 12'h01C, 0);
      if (rd[2] === 1'b0) break;
    end
    chk(rd[2], 0);
    xfer(1, 12'h00C, 32'h83); xfer(1, 12'h000, 32'h02); xfer(1, 12'h00C, 32'h03);
  endtask
  task automatic txf(input logic [7:0] lcr, input logic [7:0] d);
    int n;
    int c;
    int e;
    logic [7:0] m;
    logic p;
    n = 5 + lcr[1:0];
    m = d & (8'hFF >> (8 - n));
    p = lcr[5] ? ~lcr[4] : (lcr[4] ? ^m : ~^m);
    // stop length at four cycles a bit: one, or 1.5 for 5 bits, else two
    e = !lcr[2] ? 4 : ((lcr[1:0] == 2'b00) ? 6 : 8);
    xfer(1, 12'h00C, {24'h0, lcr}); xfer(1, 12'h000, {24'h0, d});
    xfer(1, 12'h000, {24'h0, d});
    for (int k = 0; k < 100 && serial_out !== 1'b0; k++) @(posedge pclk);
    @(posedge pclk); chk(serial_out, 0);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge pclk); chk(serial_out, m[i]);
    end
    if (lcr[3]) begin
      repeat (4) @(posedge pclk); chk(serial_out, p);
    end
    repeat (4) @(posedge pclk); chk(serial_out, 1);
    // counted from the second stop cycle; one idle cycle precedes the next start
    c = 0;
    do begin
      @(posedge pclk);
      c++;
    end while (serial_out !== 1'b0 && c < 20);
    chk(c, e);
    // let the second frame drain before the format changes
    repeat (50) @(posedge pclk);
  endtask
  task automatic rxf(input logic [7:0] lcr, input logic [7:0] d, input logic pb, perr);
    xfer(1, 12'h00C, {24'h0, lcr});
    if (lcr[3]) peer.send({2'b11, pb, d, 1'b0}, 11, 4);
    else peer.send({3'b111, d, 1'b0}, 10, 4);
    repeat (8) @(posedge pclk);
    xfer(0, 12'h01C, 0); chk(rd[1], perr);
    xfer(0, 12'h000, 0); chk(rd[7:0], d);
  endtask
  task t_brk;
    logic seen1;
    seen1 = 1'b0;
    xfer(1, 12'h00C, 32'h43); xfer(1, 12'h000, 32'hFF);
    repeat (60) begin
      @(posedge pclk); seen1 = seen1 | serial_out;
    end
    chk(seen1, 0);
    xfer(1, 12'h00C, 32'h03); xfer(0, 12'h01C, 0); chk({rd[10:6], rd[2]}, 0);
    chk(serial_out, 1);
  endtask
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    n_errors = 0; n_checks = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_regs; t_flush;
    foreach (lcr_tab[i]) txf(lcr_tab[i], 8'hA7);
    rxf(8'h03, 8'hA5, 0, 0); rxf(8'h1B, 8'hA5, 1, 1); rxf(8'h0B, 8'hA5, 1, 0);
    rxf(8'h2B, 8'h3C, 1, 0); rxf(8'h3B, 8'h3C, 1, 1);
    t_brk;
    final_report;
  end
  initial begin
    repeat (30000) @(posedge pclk);
    n_errors++;
    final_report;
  end
endmodule // uart_fifo_and_line_control_tb_top
